// file: rtl/scc_pkg.sv
// Package: constants and carriers for the smart card coupler control block
package scc_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int REF_CLK_HZ = 20000000;
    localparam int DEBOUNCE_US = 50;
    // Least time: no rounding; cycles per microsecond are truncated
    localparam int DEBOUNCE_CYC = (DEBOUNCE_US * (REF_CLK_HZ / 1000000) + 0);
    localparam int DEB_CNT_W = 11;

    // ****************************************
    // Programming fields and reset values
    // ****************************************
    localparam logic [1:0] CLK_DIV_1 = 2'h0;
    localparam logic [1:0] CLK_DIV_2 = 2'h1;
    localparam logic [1:0] CLK_DIV_4 = 2'h2;
    localparam logic [1:0] CLK_DIV_8 = 2'h3;
    localparam logic [1:0] ADDR_CLK_DIV = 2'h0;
    localparam logic [1:0] ADDR_CLK_STOP = 2'h1;
    localparam logic [1:0] ADDR_DET_POL = 2'h2;
    localparam logic [1:0] ADDR_CLK_LVL = 2'h3;
    localparam logic [1:0] CLK_DIV_RST = CLK_DIV_1;
    localparam logic CLK_STOP_RST = 1'b0;
    localparam logic CLK_LVL_RST = 1'b0;
    // Normally open switch: falling edge means insertion
    localparam logic DET_POL_RST = 1'b0;

    // Status selection on the address selects in normal mode
    localparam logic [1:0] STAT_SEL_CARD = 2'h0;
    localparam logic [1:0] STAT_SEL_BATT = 2'h1;
    localparam logic [1:0] STAT_SEL_SUPPLY = 2'h2;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic addr_sel_high;
        logic addr_sel_low;
        logic program_select_n;
        logic power_enable;
        logic host_reset;
        logic host_serial;
    } scc_host_s;

    typedef struct packed {
        logic batt_low;
        logic supply_low;
        logic supply_overload;
    } scc_fault_s;

    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_ON = 3'b010,
        ST_SHUT = 3'b100
    } scc_pwr_e;

endpackage

// file: rtl/scc_sync.sv
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none
module scc_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_r;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_r <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule
`default_nettype wire

// file: rtl/scc_coupler.sv
// Top: smart card coupler control logic
`timescale 1ns/100ps
`default_nettype none
module scc_coupler
    import scc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Host side
    input wire logic chip_select_n_i,
    input wire scc_pkg::scc_host_s host_i,
    output logic host_serial_o,
    output logic host_serial_oe_o,
    output logic interrupt_n_o,
    output logic interrupt_n_oe_o,
    output logic status_o,
    // Card side
    input wire logic card_presence_in_i,
    input wire logic card_serial_line_i,
    output logic card_serial_line_o,
    output logic card_serial_line_oe_o,
    output logic card_reset_out_o,
    output logic card_clock_out_o,
    // Supply monitor and converter
    input wire scc_pkg::scc_fault_s fault_i,
    output logic card_supply_en_o,
    output logic card_shutdown_sequence_o
);
    import scc_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int NSYNC = 12;
    logic [NSYNC-1:0] raw_w;
    logic [NSYNC-1:0] syn_w;
    // Reset values follow the idle level of each pin except program select and host serial, which reset low, so no false edge follows reset
    localparam logic [NSYNC-1:0] SYN_RST = {1'b1, 6'h00, 1'b1, 1'b1, 3'h0};

    assign raw_w = {chip_select_n_i, host_i, card_presence_in_i, card_serial_line_i,
                    fault_i};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            scc_sync #(.RST_VAL(SYN_RST[gi])) u_sync (
                .ref_clk_i(ref_clk_i),
                .sys_rst_i(sys_rst_i),
                .d_i(raw_w[gi]),
                .q_o(syn_w[gi])
            );
        end
    endgenerate

    logic cs_n_w;
    scc_host_s host_w;
    logic det_w;
    logic card_ser_w;
    scc_fault_s flt_w;
    assign {cs_n_w, host_w, det_w, card_ser_w, flt_w} = syn_w;

    // ****************************************
    // Edge detection on synchronised levels
    // ****************************************
    logic cs_n_d_r;
    logic pwr_d_r;
    logic ser_hold_r;
    logic host_to_card_r;
    logic cs_rise_w;
    logic cs_fall_w;
    logic pwr_rise_w;
    logic pwr_fall_w;

    assign cs_rise_w = cs_n_w & ~cs_n_d_r;
    assign cs_fall_w = ~cs_n_w & cs_n_d_r;
    assign pwr_rise_w = host_w.power_enable & ~pwr_d_r;
    assign pwr_fall_w = ~host_w.power_enable & pwr_d_r;

    // ****************************************
    // Programming mode and captured controls
    // ****************************************
    logic prog_mode_r;
    logic [1:0] clk_div_r;
    logic clk_stop_r;
    logic clk_lvl_r;
    logic det_pol_r;
    scc_host_s cap_r;
    logic [1:0] prog_addr_w;

    // Mode is latched on the falling chip select so program select may be released
    assign prog_addr_w = {host_w.addr_sel_high, host_w.addr_sel_low};

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cs_n_d_r <= 1'b1;
            pwr_d_r <= 1'b0;
            prog_mode_r <= 1'b0;
            cap_r <= '0;
            clk_div_r <= CLK_DIV_RST;
            clk_stop_r <= CLK_STOP_RST;
            clk_lvl_r <= CLK_LVL_RST;
            det_pol_r <= DET_POL_RST;
        end else begin
            cs_n_d_r <= cs_n_w;
            pwr_d_r <= host_w.power_enable;
            if (cs_fall_w) begin
                prog_mode_r <= ~host_w.program_select_n;
            end
            if (cs_rise_w) begin
                cap_r <= host_w;
                if (prog_mode_r) begin
                    case (prog_addr_w)
                        ADDR_CLK_DIV: clk_div_r <= {host_w.host_reset, host_w.host_serial};
                        ADDR_CLK_STOP: clk_stop_r <= host_w.host_serial;
                        ADDR_DET_POL: det_pol_r <= host_w.host_serial;
                        ADDR_CLK_LVL: clk_lvl_r <= host_w.host_serial;
                        default: clk_div_r <= clk_div_r;
                    endcase
                end
            end
        end
    end

    // ****************************************
    // Serial path
    // ****************************************
    logic path_en_w;
    assign path_en_w = ~cs_n_w & ~prog_mode_r;

    // Holds the last host serial value; it is what the card line sees
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ser_hold_r <= 1'b1;
            host_to_card_r <= 1'b1;
        end else begin
            if (path_en_w) begin
                ser_hold_r <= host_w.host_serial;
                host_to_card_r <= card_ser_w;
            end
        end
    end

    // ****************************************
    // Card presence debounce
    // ****************************************
    logic det_stable_r;
    logic [DEB_CNT_W-1:0] deb_cnt_r;
    logic present_w;
    logic insert_w;
    localparam logic [DEB_CNT_W-1:0] DEB_LAST = DEB_CNT_W'(DEBOUNCE_CYC - 1);

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            det_stable_r <= 1'b1;
            deb_cnt_r <= '0;
        end else begin
            if (det_w == det_stable_r) begin
                deb_cnt_r <= '0;
            end else if (deb_cnt_r == DEB_LAST) begin
                det_stable_r <= det_w;
                deb_cnt_r <= '0;
            end else begin
                deb_cnt_r <= deb_cnt_r + 1'b1;
            end
        end
    end

    // Normally open: low means present; programmed polarity inverts it
    assign present_w = det_stable_r ^ ~det_pol_r;
    assign insert_w = (deb_cnt_r == DEB_LAST) && (det_w != det_stable_r) &&
                      ((det_w ^ ~det_pol_r) == 1'b1);

    // ****************************************
    // Supply state machine
    // ****************************************
    scc_pwr_e pwr_r;
    scc_pwr_e pwr_nxt;

    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            ST_OFF: begin
                if (~cs_n_w && pwr_rise_w && !flt_w.batt_low) begin
                    pwr_nxt = ST_ON;
                end
            end
            ST_ON: begin
                if (flt_w.batt_low || flt_w.supply_overload) begin
                    pwr_nxt = ST_SHUT;
                end else if (~cs_n_w && pwr_fall_w) begin
                    pwr_nxt = ST_SHUT;
                end
            end
            ST_SHUT: pwr_nxt = ST_OFF;
            default: pwr_nxt = ST_OFF;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pwr_r <= ST_OFF;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    // ****************************************
    // Card clock divider
    // ****************************************
    // Ratios are relative to the undivided output, which already toggles each cycle
    logic [3:0] div_cnt_r;
    logic clk_bit_w;
    assign clk_bit_w = (clk_div_r == CLK_DIV_2) ? div_cnt_r[1] :
                       (clk_div_r == CLK_DIV_4) ? div_cnt_r[2] :
                       (clk_div_r == CLK_DIV_8) ? div_cnt_r[3] : 1'b0;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_r + 4'h1;
        end
    end

    // ****************************************
    // Interrupt, status and outputs
    // ****************************************
    logic irq_r;
    logic irq_set_w;
    logic card_on_w;
    logic status_nxt;
    logic [1:0] stat_sel_w;
    logic card_clk_nxt;

    assign card_on_w = (pwr_r == ST_ON);
    assign irq_set_w = insert_w || flt_w.batt_low || flt_w.supply_overload;
    assign stat_sel_w = {cap_r.addr_sel_high, cap_r.addr_sel_low};
    assign status_nxt = (stat_sel_w == STAT_SEL_CARD) ? present_w :
                        (stat_sel_w == STAT_SEL_BATT) ? ~flt_w.batt_low :
                        ~(flt_w.supply_low | flt_w.supply_overload);
    // Undivided selection toggles the output itself each cycle: 20 MHz output needs a faster clock
    assign card_clk_nxt = (!card_on_w || clk_stop_r) ? (card_on_w & clk_lvl_r) :
                          (clk_div_r == CLK_DIV_1) ? ~card_clock_out_o : clk_bit_w;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_r <= 1'b0;
            status_o <= 1'b1;
            card_reset_out_o <= 1'b0;
            card_clock_out_o <= 1'b0;
            host_serial_o <= 1'b0;
            host_serial_oe_o <= 1'b0;
            card_serial_line_o <= 1'b0;
            card_serial_line_oe_o <= 1'b0;
            interrupt_n_o <= 1'b0;
            interrupt_n_oe_o <= 1'b0;
            card_supply_en_o <= 1'b0;
            card_shutdown_sequence_o <= 1'b0;
        end else begin
            // Set wins over a clearing edge in the same cycle
            if (irq_set_w) begin
                irq_r <= 1'b1;
            end else if (cs_rise_w || pwr_rise_w) begin
                irq_r <= 1'b0;
            end
            interrupt_n_o <= 1'b0;
            interrupt_n_oe_o <= irq_set_w | (irq_r & ~(cs_rise_w | pwr_rise_w));
            status_o <= status_nxt;
            card_reset_out_o <= card_on_w & (path_en_w ? host_w.host_reset : card_reset_out_o)
                                & host_w.power_enable & host_w.program_select_n;
            card_clock_out_o <= card_clk_nxt;
            // Open-drain style: only lows are driven; pull-ups supply highs
            card_serial_line_o <= 1'b0;
            // A side we pull low ourselves is not echoed back, else the path latches low
            card_serial_line_oe_o <= card_on_w & path_en_w & ~ser_hold_r
                                     & ~host_serial_oe_o;
            host_serial_o <= 1'b0;
            host_serial_oe_o <= path_en_w & ~host_to_card_r & ~card_serial_line_oe_o;
            card_supply_en_o <= card_on_w;
            card_shutdown_sequence_o <= (pwr_r == ST_SHUT);
        end
    end
endmodule
`default_nettype wire

// file: sim/scc_coupler_chk.sv
// Port checker for the coupler control block
`timescale 1ns/100ps
`default_nettype none
module scc_coupler_chk
    import scc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Host side
    input wire logic chip_select_n_i,
    input wire scc_pkg::scc_host_s host_i,
    input wire logic interrupt_n_o,
    input wire logic interrupt_n_oe_o,
    // Card and supply
    input wire logic card_serial_line_oe_o,
    input wire logic card_reset_out_o,
    input wire logic card_clock_out_o,
    input wire scc_pkg::scc_fault_s fault_i,
    input wire logic card_supply_en_o,
    input wire logic card_shutdown_sequence_o
);
    // ****************************************
    // Age since the last clearing edge
    // ****************************************
    // Saturates so an old clear can never excuse a late release
    logic [3:0] clr_age_r;
    logic cs_d_r;
    logic pe_d_r;
    wire logic clr_edge = (chip_select_n_i && !cs_d_r) || (host_i.power_enable && !pe_d_r);
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            clr_age_r <= 4'hF;
            cs_d_r <= 1'b1;
            pe_d_r <= 1'b0;
        end else begin
            clr_age_r <= clr_edge ? 4'h0 : (clr_age_r == 4'hF ? 4'hF : clr_age_r + 4'h1);
            cs_d_r <= chip_select_n_i;
            pe_d_r <= host_i.power_enable;
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_off3;
        !card_supply_en_o [*3];
    endsequence
    sequence s_pdown;
        card_shutdown_sequence_o || $past(card_shutdown_sequence_o)
            || $past(card_shutdown_sequence_o, 2);
    endsequence
    a_int_never_high: assert property (!interrupt_n_o)
        else $error("interrupt pin driven high");
    a_irq_hold_flag: assert property ($fell(interrupt_n_oe_o) |-> clr_age_r <= 4'h8)
        else $error("interrupt released without clearing edge");
    a_irq_edge_clear: assert property ($rose(chip_select_n_i) && fault_i == 3'h0
        |-> ##[1:8] !interrupt_n_oe_o) else $error("interrupt not released");
    a_rst_when_off: assert property (s_off3 |-> !card_reset_out_o)
        else $error("card reset high while card off");
    a_clk_when_off: assert property (s_off3 |-> !card_clock_out_o)
        else $error("card clock active while card off");
    a_cs_high_freeze: assert property ((chip_select_n_i && card_supply_en_o) [*4]
        |-> $stable(card_serial_line_oe_o)) else $error("serial path moved with cs high");
    a_ovl_shut_off: assert property ($rose(fault_i.supply_overload)
        |-> ##[1:8] (!card_supply_en_o && interrupt_n_oe_o)) else $error("overload ignored");
    a_batt_power_down: assert property (fault_i.batt_low [*8] |-> !card_supply_en_o)
        else $error("supply on with low battery");
    a_shutdown_first: assert property ($fell(card_supply_en_o) |-> s_pdown)
        else $error("supply off without shutdown pulse");
    a_uv_keeps_on: assert property ($rose(fault_i.supply_low) && card_supply_en_o
        && !fault_i.batt_low && !fault_i.supply_overload |=> card_supply_en_o [*6])
        else $error("undervoltage changed the supply");
endmodule
bind scc_coupler scc_coupler_chk chk_u (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .chip_select_n_i(chip_select_n_i),
    .host_i(host_i), .interrupt_n_o(interrupt_n_o), .interrupt_n_oe_o(interrupt_n_oe_o),
    .card_serial_line_oe_o(card_serial_line_oe_o), .card_reset_out_o(card_reset_out_o),
    .card_clock_out_o(card_clock_out_o), .fault_i(fault_i),
    .card_supply_en_o(card_supply_en_o), .card_shutdown_sequence_o(card_shutdown_sequence_o)
);
`default_nettype wire

// file: sim/scc_card_model.sv
// Behavioural card and connector on the coupler's card side
`timescale 1ns/100ps
`default_nettype none
module scc_card_model (
    // Coupler side
    input wire logic pull_low_i,
    // Bench control
    input wire logic inserted_i,
    input wire logic tx_low_i,
    // Resolved lines
    output logic presence_o,
    output logic io_o
);
    // Normally open switch to ground over a pull-up: insertion pulls low
    assign presence_o = !inserted_i;
    // Open-drain line with pull-up; an absent card cannot drive it
    assign io_o = !(pull_low_i || (tx_low_i && inserted_i));
endmodule
`default_nettype wire

// file: sim/tb_scc_coupler.sv
// Self-checking testbench of the coupler control block
`timescale 1ns/100ps
`default_nettype none
module tb_scc_coupler;
    import scc_pkg::*;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cs_n = 1'b1;
    scc_host_s host = 6'h08;
    scc_host_s host_w;
    scc_fault_s fault = 3'h0;
    logic hs_drv = 1'b1;
    logic inserted = 1'b0;
    logic tx_low = 1'b0;
    logic host_oe, irq_n, irq_oe, status, card_io, card_oe, crst, cclk, sup_en, presence;
    int n_mismatch = 0;
    int cmp_count = 0;
    int i;
    always #25 ref_clk_i = ~ref_clk_i;
    // Host serial wire: pull-up, bench and coupler may pull low
    assign host_w = {host[5:1], hs_drv & ~host_oe};
    scc_card_model card_u (.pull_low_i(card_oe), .inserted_i(inserted), .tx_low_i(tx_low),
        .presence_o(presence), .io_o(card_io));
    scc_coupler dut_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .chip_select_n_i(cs_n),
        .host_i(host_w), .host_serial_o(), .host_serial_oe_o(host_oe), .interrupt_n_o(irq_n),
        .interrupt_n_oe_o(irq_oe), .status_o(status), .card_presence_in_i(presence),
        .card_serial_line_i(card_io), .card_serial_line_o(), .card_serial_line_oe_o(card_oe),
        .card_reset_out_o(crst), .card_clock_out_o(cclk), .fault_i(fault),
        .card_supply_en_o(sup_en), .card_shutdown_sequence_o());
    // ****************************************
    // Tasks
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One chip-select cycle; fields are taken at the rising edge
    task automatic bus(input logic pgm_n, input logic [1:0] a, input logic pe,
        input logic d1, input logic d0);
        @(posedge ref_clk_i);
        host.program_select_n <= pgm_n;
        @(posedge ref_clk_i);
        cs_n <= 1'b0;
        cyc(4);
        {host.addr_sel_high, host.addr_sel_low} <= a;
        host.power_enable <= pe;
        host.host_reset <= d1;
        hs_drv <= d0;
        cyc(6);
        cs_n <= 1'b1;
        cyc(8);
    endtask
    task automatic period(input int exp_p);
        int n;
        int r1;
        int r2;
        logic prev;
        n = 0;
        r1 = 0;
        r2 = 0;
        prev = cclk;
        repeat (60) begin
            @(posedge ref_clk_i);
            n++;
            if (cclk && !prev && r1 != 0 && r2 == 0) r2 = n;
            if (cclk && !prev && r1 == 0) r1 = n;
            prev = cclk;
        end
        chk(16'(r2 - r1), 16'(exp_p));
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #1500000;
        n_mismatch++;
        end_sim;
    end
    initial begin
        cyc(2);
        chk(status, 1'b1);
        chk(sup_en, 1'b0);
        sys_rst_i <= 1'b0;
        cyc(3);
        $display("reset test done");
        bus(1'b0, ADDR_DET_POL, 1'b0, 1'b0, 1'b1);
        bus(1'b1, STAT_SEL_CARD, 1'b0, 1'b0, 1'b1);
        chk(status, 1'b1);
        bus(1'b0, ADDR_DET_POL, 1'b0, 1'b0, 1'b0);
        bus(1'b1, STAT_SEL_CARD, 1'b0, 1'b0, 1'b1);
        chk(status, 1'b0);
        $display("polarity test done");
        bus(1'b1, STAT_SEL_CARD, 1'b1, 1'b1, 1'b1);
        chk(sup_en, 1'b1);
        chk(crst, 1'b1);
        bus(1'b1, STAT_SEL_CARD, 1'b1, 1'b0, 1'b1);
        chk(crst, 1'b0);
        $display("power test done");
        inserted <= 1'b1;
        cyc(DEBOUNCE_CYC - 100);
        chk(irq_oe, 1'b0);
        cyc(200);
        chk(irq_oe, 1'b1);
        bus(1'b1, STAT_SEL_CARD, 1'b1, 1'b0, 1'b1);
        chk(irq_oe, 1'b0);
        chk(status, 1'b1);
        $display("insertion test done");
        cs_n <= 1'b0;
        cyc(6);
        hs_drv <= 1'b0;
        cyc(6);
        chk(card_oe, 1'b1);
        hs_drv <= 1'b1;
        tx_low <= 1'b1;
        cyc(6);
        chk(card_oe, 1'b0);
        chk(host_oe, 1'b1);
        tx_low <= 1'b0;
        cs_n <= 1'b1;
        cyc(6);
        hs_drv <= 1'b0;
        cyc(6);
        chk(card_oe, 1'b0);
        hs_drv <= 1'b1;
        $display("serial test done");
        for (i = 0; i < 4; i++) begin
            bus(1'b0, ADDR_CLK_DIV, 1'b1, i[1], i[0]);
            period(2 << i);
        end
        for (i = 1; i >= 0; i--) begin
            bus(1'b0, ADDR_CLK_LVL, 1'b1, 1'b0, i[0]);
            bus(1'b0, ADDR_CLK_STOP, 1'b1, 1'b0, 1'b1);
            repeat (20) begin
                cyc(1);
                chk(cclk, i[0]);
            end
        end
        bus(1'b0, ADDR_CLK_STOP, 1'b1, 1'b0, 1'b0);
        period(16);
        $display("clock test done");
        fault.supply_low <= 1'b1;
        cyc(10);
        chk(sup_en, 1'b1);
        bus(1'b1, STAT_SEL_SUPPLY, 1'b1, 1'b0, 1'b1);
        chk(status, 1'b0);
        fault.supply_low <= 1'b0;
        fault.supply_overload <= 1'b1;
        cyc(10);
        chk(sup_en, 1'b0);
        chk(irq_oe, 1'b1);
        fault.supply_overload <= 1'b0;
        bus(1'b1, STAT_SEL_SUPPLY, 1'b0, 1'b0, 1'b1);
        chk(irq_oe, 1'b0);
        bus(1'b1, STAT_SEL_SUPPLY, 1'b1, 1'b0, 1'b1);
        chk(sup_en, 1'b1);
        fault.batt_low <= 1'b1;
        cyc(10);
        chk(sup_en, 1'b0);
        chk(irq_oe, 1'b1);
        bus(1'b1, STAT_SEL_BATT, 1'b1, 1'b0, 1'b1);
        chk(status, 1'b0);
        fault.batt_low <= 1'b0;
        $display("fault test done");
        end_sim;
    end
endmodule
`default_nettype wire
